// ---- shared/bvg_pkg.sv ----
// constants shared by the vector generator
package bvg_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ  = 20_000_000;
    localparam int unsigned SEQ_CLK_HZ  = 4_000_000;
    // sequencer tick divider, rounded down so a tick is never slower
    localparam int unsigned SEQ_DIV     = SYS_CLK_HZ / SEQ_CLK_HZ;
    localparam int unsigned DIV_W       = $clog2(SEQ_DIV);
    localparam int unsigned SEQ_SLOTS   = 12;
    localparam int unsigned SLOT_W      = $clog2(SEQ_SLOTS);
    localparam int unsigned REFRESH_GAP = 6;

    // ------------------------------------------------------------
    // sequencer slots, one per 4 MHz tick
    // ------------------------------------------------------------
    localparam logic [3:0] SLOT_REFRESH_A = 4'h0;
    localparam logic [3:0] SLOT_READ      = 4'h1;
    localparam logic [3:0] SLOT_WRITE     = 4'h2;
    localparam logic [3:0] SLOT_MINOR     = 4'h3;
    localparam logic [3:0] SLOT_MAJOR     = 4'h4;
    localparam logic [3:0] SLOT_STEP      = 4'h5;
    localparam logic [3:0] SLOT_REFRESH_B = 4'h6;
    localparam logic [3:0] SLOT_LAST      = 4'hb;

    // ------------------------------------------------------------
    // parameter file words and direction word fields
    // ------------------------------------------------------------
    localparam logic [1:0] FILE_MAJOR  = 2'h0;
    localparam logic [1:0] FILE_MINOR  = 2'h1;
    localparam logic [1:0] FILE_DIR    = 2'h2;
    localparam logic [1:0] FILE_UNUSED = 2'h3;
    localparam int unsigned DIR_CODE_HI = 2;
    localparam int unsigned DIR_ARB_BIT = 3;

    // basic direction codes used by the write-inhibit logic
    localparam logic [2:0] DIR_1 = 3'h1;
    localparam logic [2:0] DIR_2 = 3'h2;
    localparam logic [2:0] DIR_3 = 3'h3;
    localparam logic [2:0] DIR_5 = 3'h5;
    localparam logic [2:0] DIR_6 = 3'h6;
    localparam logic [2:0] DIR_7 = 3'h7;

    // per-direction x/y step: {xEn, xDown, yEn, yDown}, index = code
    // written from code 7 down to code 0
    localparam logic [31:0] DIR_STEP_TABLE = {
        4'ha, 4'h2, 4'he, 4'hc, 4'hf, 4'h3, 4'hb, 4'h8
    };
endpackage : bvg_pkg

// ---- logic/bvg_vector_gen.sv ----
// Bresenham vector generator core with refresh-interleaved bit map access
// Summary of operation
// - length counter loaded by host, decrements per pixel, zero ends the run.
// - parameter file holds major, minor, direction; fourth word has no effect.
// - datapath is 8 bits, so one run draws at most 256 pixels.
// - direction decode uses 3-bit code, arbitrary flag and adder carry.
// - arbitrary directions use carry for minor step; basic ones step every pixel.
// - decoder yields enable and up/down for each position counter.
// - error latch takes adder result while running, host value during setup.
// - execute request is synchronised into a run flag enabling vector slots.
// - refresh loads shifter and advances horizontal counter every six ticks.
// - run only starts during a refresh load slot.
// - while running, address switches to x/y for read then write.
// - each step moves x, y or both by exactly one count.
// - minor term subtracted each step; carry decides minor axis step.
// - 512-line host space on 256 lines needs odd/even write suppression.
// - no write stepping direction 2 from odd line or 6 from even line.
// - no write for 5/7 even after 6, or 1/3 odd after 2.
// - eight basic 45-degree directions, no decisions once set.
// - no carry in first phase steps both axes; carry steps major only.
// - first phase adds complemented minor plus carry-in, captures carry.
// - second phase adds major term only while carry flip-flop is clear.
// - length reaching zero clears run and returns to refresh-only.
module bvg_vector_gen
    import bvg_pkg::*;
#(
    parameter int unsigned DATA_W  = 8,
    parameter int unsigned COORD_W = 8
)(
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               clkEn,
    input  wire logic               execute_request_n,
    input  wire logic [DATA_W-1:0]  hostData,
    input  wire logic               loadX,
    input  wire logic               loadY,
    input  wire logic               loadLength,
    input  wire logic               loadError,
    input  wire logic               fileWe,
    input  wire logic [1:0]         fileAddr,
    input  wire logic [COORD_W-1:0] refreshRow,
    output logic                    runBusy,
    output logic                    vectorDone,
    output logic [COORD_W-1:0]      bmColumn,
    output logic [COORD_W-1:0]      bmRow,
    output logic                    bmVectorSel,
    output logic                    bmReadStrobe,
    output logic                    bmWriteStrobe,
    output logic                    refresh_load_shift,
    output logic [COORD_W-1:0]      hCount
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [DIV_W-1:0]   divReg;
    logic [3:0]         slotReg;
    logic               execS1Reg, execS2Reg, execS3Reg, execLvlReg;
    logic               pendReg, runReg, doneReg, carryReg;
    logic [DATA_W-1:0]  errReg, lenReg;
    logic [DATA_W-1:0]  fileReg [0:2];
    logic [COORD_W-1:0] xReg, yReg, hReg;
    logic [2:0]         stepDirReg, prevDirReg;
    logic               fromOddReg, firstReg, histValidReg;
    logic               rdReg, wrReg, loadReg, selReg;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire               tick      = clkEn && (divReg == DIV_W'(SEQ_DIV - 1));
    wire               inRefresh = (slotReg == SLOT_REFRESH_A) || (slotReg == SLOT_REFRESH_B);
    wire               execAgree = (execS2Reg == execS3Reg);
    wire               execFall  = execAgree && execLvlReg && !execS3Reg;
    wire               setup     = !runReg;
    wire [DATA_W-1:0]  majorTerm = fileReg[FILE_MAJOR];
    wire [DATA_W-1:0]  minor_axis_term = fileReg[FILE_MINOR];
    wire [2:0]         dirCode   = fileReg[FILE_DIR][DIR_CODE_HI:0];
    wire               dirArb    = fileReg[FILE_DIR][DIR_ARB_BIT];
    // minor term is stored complemented; carry-in completes the negation
    wire [DATA_W:0]    sumMinor  = {1'b0, errReg} + {1'b0, minor_axis_term} + (DATA_W+1)'(1);
    wire [DATA_W:0]    sumMajor  = {1'b0, errReg} + {1'b0, majorTerm};
    // arbitrary: carry set means major axis only, the neighbouring axial code
    wire [2:0]         effDir    = (dirArb && carryReg) ? (dirCode + 3'h1) : dirCode;
    wire [3:0]         stepBits  = DIR_STEP_TABLE[effDir*4 +: 4];
    wire               xEn       = stepBits[3];
    wire               xDown     = stepBits[2];
    wire               yEn       = stepBits[1];
    wire               yDown     = stepBits[0];
    wire               y_line_lsb = yReg[0];
    wire               inhibit1  = (stepDirReg == DIR_2 && fromOddReg)
                                || (stepDirReg == DIR_6 && !fromOddReg);
    wire               inhibit2  = histValidReg && (stepDirReg == DIR_5 || stepDirReg == DIR_7)
                                && !fromOddReg && prevDirReg == DIR_6;
    wire               inhibit3  = histValidReg && (stepDirReg == DIR_1 || stepDirReg == DIR_3)
                                && fromOddReg && prevDirReg == DIR_2;
    wire               inhibit   = !firstReg && (inhibit1 || inhibit2 || inhibit3);
    wire               vecSlot   = runReg && (slotReg == SLOT_READ || slotReg == SLOT_WRITE);
    wire [DATA_W-1:0]  errNext   = setup ? hostData : sumMinor[DATA_W-1:0];
    wire [DATA_W-1:0]  lenNext   = lenReg - DATA_W'(1);
    wire [3:0]         slotNext  = (slotReg == SLOT_LAST) ? SLOT_REFRESH_A : slotReg + 4'h1;

    // ------------------------------------------------------------
    // sequencer and execute synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            divReg    <= '0;
            slotReg   <= SLOT_REFRESH_A;
            execS1Reg <= 1'b1;
            execS2Reg <= 1'b1;
            execS3Reg <= 1'b1;
            execLvlReg <= 1'b1;
        end
        else if (clkEn)
        begin
            divReg    <= tick ? '0 : divReg + DIV_W'(1);
            execS1Reg <= execute_request_n;
            execS2Reg <= execS1Reg;
            execS3Reg <= execS2Reg;
            if (execAgree)
                execLvlReg <= execS3Reg;
            if (tick)
                slotReg <= slotNext;
        end
    end

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pendReg <= 1'b0;
            runReg  <= 1'b0;
            doneReg <= 1'b0;
        end
        else if (clkEn)
        begin
            doneReg <= 1'b0;
            if (execFall && !runReg)
                pendReg <= 1'b1;
            if (tick && inRefresh && pendReg && !runReg)
            begin
                runReg  <= 1'b1;
                pendReg <= 1'b0;
            end
            else if (tick && runReg && slotReg == SLOT_STEP && lenNext == '0)
            begin
                runReg  <= 1'b0;
                doneReg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // parameter file, counters and error arithmetic
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            carryReg     <= 1'b0;
            stepDirReg   <= '0;
            prevDirReg   <= '0;
            fromOddReg   <= 1'b0;
            firstReg     <= 1'b1;
            histValidReg <= 1'b0;
            errReg       <= '0;
            lenReg       <= '0;
            xReg         <= '0;
            yReg         <= '0;
            for (int i = 0; i < 3; i++)
                fileReg[i] <= '0;
        end
        else if (clkEn)
        begin
            if (setup)
            begin
                // fourth word is decoded away so it cannot disturb the file
                if (fileWe && fileAddr != FILE_UNUSED)
                    fileReg[fileAddr] <= hostData;
                if (loadX)
                    xReg <= hostData[COORD_W-1:0];
                if (loadY)
                    yReg <= hostData[COORD_W-1:0];
                if (loadLength)
                    lenReg <= hostData;
                if (loadError)
                    errReg <= errNext;
                firstReg     <= 1'b1;
                histValidReg <= 1'b0;
            end
            else if (tick)
            begin
                case (slotReg)
                    SLOT_MINOR:
                    begin
                        errReg   <= errNext;
                        carryReg <= sumMinor[DATA_W];
                    end
                    SLOT_MAJOR:
                    begin
                        if (!carryReg)
                            errReg <= sumMajor[DATA_W-1:0];
                    end
                    SLOT_STEP:
                    begin
                        lenReg <= lenNext;
                        if (lenNext != '0)
                        begin
                            // one count per axis at most, basic codes ignore carry
                            if (xEn)
                                xReg <= xDown ? xReg - COORD_W'(1) : xReg + COORD_W'(1);
                            if (yEn)
                                yReg <= yDown ? yReg - COORD_W'(1) : yReg + COORD_W'(1);
                            prevDirReg   <= stepDirReg;
                            histValidReg <= !firstReg;
                            stepDirReg   <= effDir;
                            fromOddReg   <= y_line_lsb;
                            firstReg     <= 1'b0;
                        end
                    end
                    default:
                    begin
                        errReg <= errReg;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // bit map strobes and refresh counter
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            hReg    <= '0;
            rdReg   <= 1'b0;
            wrReg   <= 1'b0;
            loadReg <= 1'b0;
            selReg  <= 1'b0;
        end
        else if (clkEn)
        begin
            loadReg <= tick && inRefresh;
            rdReg   <= tick && (inRefresh || (runReg && slotReg == SLOT_READ));
            wrReg   <= tick && runReg && slotReg == SLOT_WRITE && !inhibit;
            if (tick)
                // held over the read and the write-back strobes, never over a refresh read
                selReg <= runReg && (slotReg == SLOT_READ || slotReg == SLOT_WRITE);
            if (tick && inRefresh)
                hReg <= hReg + COORD_W'(1);
        end
    end

    assign runBusy            = runReg;
    assign vectorDone         = doneReg;
    assign bmVectorSel        = selReg;
    assign bmColumn           = selReg ? xReg : hReg;
    assign bmRow              = selReg ? yReg : refreshRow;
    assign bmReadStrobe       = rdReg;
    assign bmWriteStrobe      = wrReg;
    assign refresh_load_shift = loadReg;
    assign hCount             = hReg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    run_start_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(runReg) |-> $past(inRefresh) && $past(tick))
        else $error("run started outside a refresh slot");
    done_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
        vectorDone |-> !runBusy && lenReg == '0)
        else $error("done without run cleared and length zero");
    len_step_a: assert property (@(posedge sys_clk) disable iff (rst)
        (tick && runReg && slotReg == SLOT_STEP) |=> lenReg == $past(lenReg) - DATA_W'(1))
        else $error("length counter did not decrement by one");
    carry_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (tick && runReg && slotReg == SLOT_MAJOR && carryReg) |=> $stable(errReg))
        else $error("error register changed with carry set");
    minor_sum_a: assert property (@(posedge sys_clk) disable iff (rst)
        (tick && runReg && slotReg == SLOT_MINOR) |=> carryReg == $past(sumMinor[DATA_W]))
        else $error("carry flip-flop not loaded from adder");
    inhibit_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        (tick && runReg && slotReg == SLOT_WRITE && inhibit) |=> !bmWriteStrobe)
        else $error("write issued while inhibited");
    addr_select_a: assert property (@(posedge sys_clk) disable iff (rst)
        bmWriteStrobe |-> bmVectorSel && bmColumn == xReg && bmRow == yReg)
        else $error("vector write not addressed by x and y");
    unit_step_a: assert property (@(posedge sys_clk) disable iff (rst || setup)
        runReg |=> (xReg == $past(xReg) || xReg == $past(xReg) + COORD_W'(1)
                 || xReg == $past(xReg) - COORD_W'(1)))
        else $error("x moved by more than one count");
    unused_word_a: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && fileWe && fileAddr == FILE_UNUSED) |=> $stable(fileReg[FILE_MAJOR])
        && $stable(fileReg[FILE_MINOR]) && $stable(fileReg[FILE_DIR]))
        else $error("unused file word disturbed the file");
    refresh_load_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(refresh_load_shift) |-> hCount == $past(hCount) + COORD_W'(1))
        else $error("refresh counter not advanced with load");
endmodule : bvg_vector_gen

// ---- testbench/bvg_bitmap_model.sv ----
// bit map memory stand-in that logs every vector read and write-back
module bvg_bitmap_model
    import bvg_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic [7:0] bmColumn,
    input wire logic [7:0] bmRow,
    input wire logic       bmVectorSel,
    input wire logic       bmReadStrobe,
    input wire logic       bmWriteStrobe
);
    timeunit 1ns;
    timeprecision 1ps;
    // entry is {wrote, row, column}, one per vector read
    logic [16:0] frameLog[$];
    int          addrBad = 0;
    always @(posedge sys_clk)
    begin
        if (rst)
            frameLog.delete();
        if (bmReadStrobe && bmVectorSel)
            frameLog.push_back({1'b0, bmRow, bmColumn});
        if (bmWriteStrobe)
        begin
            // write-back must hit the location just read
            if (!bmVectorSel || frameLog.size() == 0 || frameLog[$][15:0] !== {bmRow, bmColumn})
                addrBad++;
            else
                frameLog[$][16] = 1'b1;
        end
    end
endmodule : bvg_bitmap_model

// ---- testbench/bvg_vector_gen_tb_top.sv ----
// self-checking bench for the vector generator
module bvg_vector_gen_tb_top
    import bvg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk, rst, clkEn, execute_request_n, loadX, loadY, loadLength, loadError, fileWe;
    logic [1:0] fileAddr;
    logic [7:0] hostData, refreshRow, bmColumn, bmRow, hCount, hLast;
    logic       runBusy, vectorDone, bmVectorSel, bmReadStrobe, bmWriteStrobe, refresh_load_shift;
    int         badCount = 0;
    int         checkCount = 0;
    int         cycles = 0;
    int         gap = 0;
    bit         seenLoad, runSeen;
    logic [15:0] expAddr[$];
    int          expWr[$];
    int          dxT[8] = '{1, 1, 0, -1, -1, -1, 0, 1};
    int          dyT[8] = '{0, -1, -1, -1, 0, 1, 1, 1};

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    bvg_vector_gen dut_u (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .execute_request_n(execute_request_n),
        .hostData(hostData), .loadX(loadX), .loadY(loadY), .loadLength(loadLength), .loadError(loadError),
        .fileWe(fileWe), .fileAddr(fileAddr), .refreshRow(refreshRow), .runBusy(runBusy),
        .vectorDone(vectorDone), .bmColumn(bmColumn), .bmRow(bmRow), .bmVectorSel(bmVectorSel),
        .bmReadStrobe(bmReadStrobe), .bmWriteStrobe(bmWriteStrobe), .refresh_load_shift(refresh_load_shift),
        .hCount(hCount));
    bvg_bitmap_model model_u (.sys_clk(sys_clk), .rst(rst), .bmColumn(bmColumn), .bmRow(bmRow),
        .bmVectorSel(bmVectorSel), .bmReadStrobe(bmReadStrobe), .bmWriteStrobe(bmWriteStrobe));

    // ------
    // helpers
    // ------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            badCount++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tallyAndFinish

    // sel 0..3 register strobes, 4..7 parameter file words
    task automatic hostLoad(input int sel, input logic [7:0] d);
        @(posedge sys_clk);
        hostData <= d;
        {loadX, loadY, loadLength, loadError} <= {sel == 0, sel == 1, sel == 2, sel == 3};
        fileWe <= (sel >= 4);
        fileAddr <= 2'(sel);
        @(posedge sys_clk);
        {loadX, loadY, loadLength, loadError, fileWe} <= '0;
    endtask : hostLoad

    task automatic predict(input logic [7:0] x, y, len, err, maj, minc, input logic [3:0] dw);
        int n;
        int wr;
        logic [8:0] s;
        logic [2:0] d, prevD;
        logic cy, inh;
        n = (len == 0) ? 256 : len;
        wr = 1;
        prevD = 3'h0;
        expAddr.delete();
        expWr.delete();
        for (int k = 0; k < n; k++)
        begin
            expAddr.push_back({y, x});
            expWr.push_back(wr);
            s = {1'b0, err} + minc + 9'h001;
            cy = s[8];
            err = cy ? s[7:0] : s[7:0] + maj;
            d = dw[2:0] + ((dw[3] && cy) ? 3'h1 : 3'h0);
            inh = (d == 2 && y[0]) || (d == 6 && !y[0]) || ((d == 5 || d == 7) && !y[0] && prevD == 6)
                || ((d == 1 || d == 3) && y[0] && prevD == 2);
            // history before the first step is not pinned down, so skip that case
            wr = (k == 0 && d[0]) ? 2 : int'(!inh);
            prevD = d;
            x = 8'(int'(x) + dxT[d]);
            y = 8'(int'(y) + dyT[d]);
        end
    endtask : predict

    // mode 0 plain, 1 loads and execute while running, 2 reset mid-run
    task automatic runVec(input logic [7:0] x, y, len, maj, m, input logic [3:0] dw, input int mode);
        int t;
        predict(x, y, len, maj >> 1, maj, ~m, dw);
        hostLoad(0, x);
        hostLoad(1, y);
        hostLoad(2, len);
        hostLoad(3, maj >> 1);
        hostLoad(4, maj);
        hostLoad(5, ~m);
        hostLoad(6, {4'h0, dw});
        hostLoad(7, 8'($urandom));
        @(posedge sys_clk);
        model_u.frameLog.delete();
        execute_request_n <= 1'b0;
        t = 0;
        while (runBusy !== 1'b1 && t < 200)
        begin
            @(posedge sys_clk);
            t++;
        end
        check("runStart", runBusy, 1'b1);
        execute_request_n <= 1'b1;
        if (mode == 2)
        begin
            repeat (200) @(posedge sys_clk);
            rst <= 1'b1;
            repeat (2) @(posedge sys_clk);
            rst <= 1'b0;
            repeat (200) @(posedge sys_clk);
            check("abortRun", runBusy, 1'b0);
            check("abortFrames", model_u.frameLog.size(), 0);
            return;
        end
        if (mode == 1)
        begin
            hostLoad(0, 8'h5a);
            hostLoad(2, 8'h03);
            hostLoad(3, 8'h77);
            hostLoad(5, 8'h00);
            execute_request_n <= 1'b0;
        end
        t = 0;
        while (vectorDone !== 1'b1 && t < 17000)
        begin
            @(posedge sys_clk);
            t++;
        end
        check("done", vectorDone, 1'b1);
        repeat (100) @(posedge sys_clk);
        check("noRestart", runBusy, 1'b0);
        execute_request_n <= 1'b1;
        check("frames", model_u.frameLog.size(), expAddr.size());
        for (int k = 0; k < expAddr.size() && k < model_u.frameLog.size(); k++)
        begin
            check("pixelAddr", model_u.frameLog[k][15:0], expAddr[k]);
            if (expWr[k] != 2)
                check("pixelWrite", model_u.frameLog[k][16], expWr[k][0]);
        end
        check("addrPair", model_u.addrBad, 0);
    endtask : runVec

    // ------
    // monitors
    // ------
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            badCount++;
            tallyAndFinish();
        end
        if (rst)
        begin
            seenLoad = 0;
            runSeen = 0;
            gap = 0;
        end
        else
        begin
            gap++;
            if (refresh_load_shift)
            begin
                if (seenLoad)
                begin
                    check("refreshGap", gap, 30);
                    check("hStep", 8'(hCount - hLast), 8'h01);
                end
                hLast = hCount;
                gap = 0;
                seenLoad = 1;
                refreshRow <= 8'($urandom);
            end
            if (runBusy && !runSeen)
                check("runAtRefresh", gap <= 6, 1'b1);
            runSeen = runBusy;
            if (vectorDone)
                check("doneDrops", runBusy, 1'b0);
            if (bmReadStrobe && !bmVectorSel)
                check("refreshRow", bmRow, refreshRow);
        end
    end

    // ------
    // main sequence
    // ------
    initial
    begin
        int seed;
        seed = $urandom(9);
        {rst, clkEn, execute_request_n} = 3'b111;
        {loadX, loadY, loadLength, loadError, fileWe} = '0;
        {fileAddr, hostData, refreshRow} = '0;
        repeat (6) @(posedge sys_clk);
        check("rstRun", runBusy, 1'b0);
        check("rstDone", vectorDone, 1'b0);
        check("rstH", hCount, 8'h00);
        rst <= 1'b0;
        // every code, basic and in-between, with a minor 3 of major 5 slope
        for (int d = 0; d < 16; d++)
            runVec(8'($urandom), 8'($urandom), 8'h06, 8'h05, 8'h03, 4'(d), (d == 3) ? 1 : 0);
        for (int i = 0; i < 8; i++)
        begin
            logic [7:0] maj;
            maj = 8'(1 + $urandom % 40);
            runVec(8'($urandom), 8'($urandom), 8'(1 + $urandom % maj), maj, 8'($urandom % (maj + 1)),
                4'($urandom), 0);
        end
        runVec(8'h10, 8'h21, 8'h01, 8'h01, 8'h00, 4'h6, 0);
        runVec(8'hf0, 8'h33, 8'h00, 8'hff, 8'h40, 4'h9, 0);
        runVec(8'h40, 8'h40, 8'h0a, 8'h0a, 8'h04, 4'hd, 2);
        runVec(8'h02, 8'h03, 8'h05, 8'h09, 8'h09, 4'hb, 0);
        tallyAndFinish();
    end
endmodule : bvg_vector_gen_tb_top
